/* File: src/hpsp_pkg.sv */
// Shared constants and types for the host parallel slave port.
// Assumes one system clock; every host pin is already synchronous to it.
package hpsp_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int LANE_W = 8;                   // One group of data lanes
  localparam int WORD_W = 16;                  // Fast mode word

  // ---------------------------------------------------------------
  // Address pin encodings
  // ---------------------------------------------------------------
  localparam logic MODE_COMM = 1'b0;           // Communication/control mode
  localparam logic MODE_FAST = 1'b1;           // Fast 16-bit data mode
  localparam logic SEL_DATA  = 1'b0;           // Data transfer in mode 0
  localparam logic SEL_CTRL  = 1'b1;           // Status (read) or control (write)

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [WORD_W-1:0] WORD_RESET = 16'h0000;
  localparam logic [LANE_W-1:0] LANE_ZERO  = 8'h00;

  // One host write as handed to the core
  typedef struct packed {
    logic              mode;                   // Mode pin at the write
    logic              sel;                    // Type pin, zero in fast mode
    logic [WORD_W-1:0] data;                   // Upper byte zero in mode 0
  } hpsp_word_t;

  localparam hpsp_word_t HPSP_WORD_RESET = '{mode: MODE_COMM, sel: SEL_DATA,
                                             data: WORD_RESET};

endpackage : hpsp_pkg

/* File: src/hpsp_buffer.sv */
// Two-entry buffer with valid/ready on both sides.
// Assumes the sink may stall at will; a full buffer drops its in_ready.
module hpsp_buffer
  import hpsp_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       reset_n,
  // Filling side
  input  wire logic       in_valid,
  output logic            in_ready,
  input  hpsp_word_t      in_word,
  // Draining side
  output logic            out_valid,
  input  wire logic       out_ready,
  output hpsp_word_t      out_word
);

  // ---------------------------------------------------------------
  // Storage: head feeds the output, spare catches a stalled word
  // ---------------------------------------------------------------
  hpsp_word_t head_reg, head_next;             // Word presented to sink
  hpsp_word_t spare_reg, spare_next;           // Second entry
  logic       head_v_reg, head_v_next;         // Head holds a word
  logic       spare_v_reg, spare_v_next;       // Spare holds a word

  // Next-state: pop first, then place the new word
  always_comb begin
    head_next    = head_reg;
    spare_next   = spare_reg;
    head_v_next  = head_v_reg;
    spare_v_next = spare_v_reg;
    if (head_v_reg && out_ready) begin
      if (spare_v_reg) begin
        // Spare moves up so order is kept
        head_next    = spare_reg;
        spare_v_next = 1'b0;
      end else begin
        head_v_next = 1'b0;
      end
    end
    if (in_valid && !spare_v_reg) begin
      if (!head_v_next) begin
        head_next   = in_word;
        head_v_next = 1'b1;
      end else begin
        spare_next   = in_word;
        spare_v_next = 1'b1;
      end
    end
  end

  // Registers only
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      head_reg    <= HPSP_WORD_RESET;
      spare_reg   <= HPSP_WORD_RESET;
      head_v_reg  <= 1'b0;
      spare_v_reg <= 1'b0;
    end else begin
      head_reg    <= head_next;
      spare_reg   <= spare_next;
      head_v_reg  <= head_v_next;
      spare_v_reg <= spare_v_next;
    end
  end

  // Ready is honest: refused only while both entries are taken
  assign in_ready  = !spare_v_reg;
  assign out_valid = head_v_reg;
  assign out_word  = head_reg;

endmodule : hpsp_buffer

/* File: src/hpsp_port.sv */
// Host parallel slave port: strobed host pins on one side, core streams
// on the other. Assumes all host pins are synchronous to clk_sys and the
// testbench resolves the data lanes from the output enables.
module hpsp_port
  import hpsp_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset_n,
  // Host strobes and address
  input  wire logic              cs_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic              transfer_type_select,
  input  wire logic              transfer_mode_select,
  // Host data lanes, split into in/out/enable
  input  wire logic [LANE_W-1:0] lower_data_lanes_in,
  input  wire logic [LANE_W-1:0] upper_data_lanes_in,
  output logic      [LANE_W-1:0] lower_data_lanes_out,
  output logic      [LANE_W-1:0] upper_data_lanes_out,
  output logic                   lower_data_lanes_oe,
  output logic                   upper_data_lanes_oe,
  // Host flags
  output logic                   irq,
  output logic                   transfer_ready,
  // Core side: words written by the host
  output logic                   rx_valid,
  input  wire logic              rx_ready,
  output hpsp_word_t             rx_word,
  // Core side: words for the host to read
  input  wire logic              tx_valid,
  output logic                   tx_ready,
  input  wire logic [WORD_W-1:0] tx_data,
  // Core side: status byte seen by mode 0 status reads
  input  wire logic [LANE_W-1:0] status_byte
);

  // ---------------------------------------------------------------
  // Strobe decode
  // ---------------------------------------------------------------
  logic rd_act;                                // Select and read both low
  logic wr_act;                                // Select and write both low
  logic rd_start;                              // First cycle of a read
  logic wr_commit;                             // Write strobe rose under select
  logic fast;                                  // Fast mode selected now

  // Previous pin levels for edge detection
  logic rd_act_reg, rd_act_next;
  logic wr_n_reg, wr_n_next;
  logic cs_n_reg, cs_n_next;

  assign fast      = (transfer_mode_select == MODE_FAST);
  assign rd_act    = !cs_n && !rd_n;
  assign wr_act    = !cs_n && !wr_n;
  assign rd_start  = rd_act && !rd_act_reg;
  // Rising write strobe while select was low in the cycle before the rise
  assign wr_commit = !wr_n_reg && wr_n && !cs_n_reg;

  // ---------------------------------------------------------------
  // Write capture
  // ---------------------------------------------------------------
  hpsp_word_t wr_word_reg, wr_word_next;       // Last word seen under strobe
  logic       wr_pend_reg, wr_pend_next;       // Word waiting for buffer
  hpsp_word_t pend_word_reg, pend_word_next;   // Word offered to buffer
  logic       buf_in_ready;                    // Buffer has room

  // Sample lanes every cycle the strobe is low; the rise commits them
  always_comb begin
    wr_word_next = wr_word_reg;
    pend_word_next = pend_word_reg;
    wr_pend_next = wr_pend_reg;
    if (wr_act) begin
      wr_word_next.mode = transfer_mode_select;
      if (fast) begin
        // Type pin plays no part in fast mode
        wr_word_next.sel  = SEL_DATA;
        wr_word_next.data = {upper_data_lanes_in, lower_data_lanes_in};
      end else begin
        wr_word_next.sel  = transfer_type_select;
        wr_word_next.data = {LANE_ZERO, lower_data_lanes_in};
      end
    end
    // Offered word leaves once the buffer takes it
    if (wr_pend_reg && buf_in_ready) begin
      wr_pend_next = 1'b0;
    end
    // A fresh commit wins over the hand-off in the same cycle
    if (wr_commit) begin
      pend_word_next = wr_word_reg;
      wr_pend_next   = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Outbound holding and read data
  // ---------------------------------------------------------------
  logic [WORD_W-1:0] hold_reg, hold_next;      // Word waiting for the host
  logic              full_reg, full_next;      // Holding register valid
  logic [WORD_W-1:0] dout_reg, dout_next;      // Word on the lanes
  logic              oe_lo_reg, oe_lo_next;    // Lower lanes driven
  logic              oe_hi_reg, oe_hi_next;    // Upper lanes driven
  logic              txr_reg, txr_next;        // Core may hand over a word
  logic              irq_reg, irq_next;        // Interrupt to host
  logic              xrdy_reg, xrdy_next;      // Transfer ready to host
  logic              last_rd_reg, last_rd_next;// Last fast access was a read

  // Read path: choose the word at the start, pop data reads
  always_comb begin
    hold_next    = hold_reg;
    full_next    = full_reg;
    dout_next    = dout_reg;
    last_rd_next = last_rd_reg;
    if (rd_start) begin
      if (fast) begin
        // Full word, type pin ignored
        dout_next    = hold_reg;
        full_next    = 1'b0;
        last_rd_next = 1'b1;
      end else if (transfer_type_select == SEL_CTRL) begin
        // Status read does not consume data
        dout_next = {LANE_ZERO, status_byte};
      end else begin
        dout_next = {LANE_ZERO, hold_reg[LANE_W-1:0]};
        full_next = 1'b0;
      end
    end
    if (wr_commit && fast) begin
      last_rd_next = 1'b0;
    end
    // Refill only into an empty holding register
    if (tx_valid && txr_reg) begin
      hold_next = tx_data;
      full_next = 1'b1;
    end
  end

  // Pin drivers and host flags, all registered
  always_comb begin
    // Drive only during a read; released otherwise
    oe_lo_next = rd_act;
    oe_hi_next = rd_act && fast;
    // Ready to the core follows the holding register
    txr_next   = !full_next;
    // Held data raises the request; any read holds it low
    irq_next   = full_next && !rd_act;
    // Next access allowed once strobes are back, write handed off,
    // and after a fast read the next word is already held
    xrdy_next  = !rd_act && !wr_act && !wr_pend_next &&
                 (!last_rd_next || full_next);
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_comb begin
    rd_act_next = rd_act;
    wr_n_next   = wr_n;
    cs_n_next   = cs_n;
  end

  // Edge history: idle pins after reset so no false strobe is seen
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rd_act_reg <= 1'b0;
      wr_n_reg   <= 1'b1;
      cs_n_reg   <= 1'b1;
    end else begin
      rd_act_reg <= rd_act_next;
      wr_n_reg   <= wr_n_next;
      cs_n_reg   <= cs_n_next;
    end
  end

  // Write capture state
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wr_word_reg   <= HPSP_WORD_RESET;
      pend_word_reg <= HPSP_WORD_RESET;
      wr_pend_reg   <= 1'b0;
    end else begin
      wr_word_reg   <= wr_word_next;
      pend_word_reg <= pend_word_next;
      wr_pend_reg   <= wr_pend_next;
    end
  end

  // Read path and flags; transfer ready low until the first edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      hold_reg    <= WORD_RESET;
      full_reg    <= 1'b0;
      dout_reg    <= WORD_RESET;
      oe_lo_reg   <= 1'b0;
      oe_hi_reg   <= 1'b0;
      txr_reg     <= 1'b0;
      irq_reg     <= 1'b0;
      xrdy_reg    <= 1'b0;
      last_rd_reg <= 1'b0;
    end else begin
      hold_reg    <= hold_next;
      full_reg    <= full_next;
      dout_reg    <= dout_next;
      oe_lo_reg   <= oe_lo_next;
      oe_hi_reg   <= oe_hi_next;
      txr_reg     <= txr_next;
      irq_reg     <= irq_next;
      xrdy_reg    <= xrdy_next;
      last_rd_reg <= last_rd_next;
    end
  end

  // ---------------------------------------------------------------
  // Write buffer toward the core
  // ---------------------------------------------------------------
  // A stalled core fills it; transfer ready then stays low so the
  // host is held off in fast mode. Mode 0 writes have no pacing, so
  // a host that outruns a stalled core overwrites the pending word.
  hpsp_buffer u_buffer (
    .clk_sys   (clk_sys),
    .reset_n   (reset_n),
    .in_valid  (wr_pend_reg),
    .in_ready  (buf_in_ready),
    .in_word   (pend_word_reg),
    .out_valid (rx_valid),
    .out_ready (rx_ready),
    .out_word  (rx_word)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign lower_data_lanes_out = dout_reg[LANE_W-1:0];
  assign upper_data_lanes_out = dout_reg[WORD_W-1:LANE_W];
  assign lower_data_lanes_oe  = oe_lo_reg;
  assign upper_data_lanes_oe  = oe_hi_reg;
  assign irq                  = irq_reg;
  assign transfer_ready       = xrdy_reg;
  assign tx_ready             = txr_reg;

endmodule : hpsp_port

/* File: bench/hpsp_port_asserts.sv */
// Concurrent checks on the pins of the host parallel slave port.
// Assumes every host pin is synchronous to clk_sys; bound in from the bench.
module hpsp_port_asserts
  import hpsp_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              reset_n,
  // Host strobes, address and flags
  input wire logic              cs_n,
  input wire logic              rd_n,
  input wire logic              wr_n,
  input wire logic              transfer_type_select,
  input wire logic              transfer_mode_select,
  input wire logic [LANE_W-1:0] lower_data_lanes_out,
  input wire logic              lower_data_lanes_oe,
  input wire logic              upper_data_lanes_oe,
  input wire logic              irq,
  input wire logic              transfer_ready,
  // Core side
  input wire logic              rx_valid,
  input hpsp_word_t             rx_word,
  input wire logic              tx_valid,
  input wire logic              tx_ready,
  input wire logic [LANE_W-1:0] status_byte
);
  timeunit 1ns;
  timeprecision 1ns;
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Read seen at one edge, lanes driven after it
  property p_read_drive; !cs_n && !rd_n |=> lower_data_lanes_oe; endproperty
  a_read_drive: assert property (p_read_drive) else $error("Lanes not driven");
  // Lanes let go one cycle after select or strobe rises
  property p_release; cs_n || rd_n |=> !lower_data_lanes_oe && !upper_data_lanes_oe; endproperty
  a_release: assert property (p_release) else $error("Lanes not released");
  // Any read pulls the request down, status reads too
  property p_irq_clear; !cs_n && !rd_n |=> !irq; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("Request not cleared");
  // Upper group stays off the bus in mode 0
  property p_upper_idle; !cs_n && !rd_n && !transfer_mode_select |=> !upper_data_lanes_oe;
  endproperty
  a_upper_idle: assert property (p_upper_idle) else $error("Upper lanes in mode 0");
  // Status read returns the status byte of the first read cycle
  property p_status;
    !cs_n && !rd_n && $past(cs_n | rd_n) && !transfer_mode_select && transfer_type_select
      |=> lower_data_lanes_out == $past(status_byte);
  endproperty
  a_status: assert property (p_status) else $error("Status byte wrong");
  // Commit on strobe rise reaches an empty buffer two cycles later
  property p_commit; wr_n && $past(!cs_n && !wr_n) && !rx_valid |-> ##2 rx_valid; endproperty
  a_commit: assert property (p_commit) else $error("Write not delivered");
  // Fast mode drops the type pin, mode 0 zeroes the upper byte
  property p_word_shape;
    $rose(rx_valid) |-> (rx_word.mode == MODE_FAST) ? rx_word.sel == SEL_DATA
                                                   : rx_word.data[15:8] == LANE_ZERO;
  endproperty
  a_word_shape: assert property (p_word_shape) else $error("Word shape wrong");
  // Host is held off right after a fast write
  property p_ready_hold; wr_n && $past(!cs_n && !wr_n) && transfer_mode_select |=> !transfer_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold) else $error("Ready during write");
  // A held word with no read in sight raises the request
  property p_irq_raise; tx_valid && tx_ready ##1 (cs_n && rd_n)[*3] |-> irq; endproperty
  a_irq_raise: assert property (p_irq_raise) else $error("Request not raised");
endmodule : hpsp_port_asserts

/* File: bench/hpsp_host_model.sv */
// Host bus master model: strobes, address pins and the shared data lanes.
// Assumes tasks are entered at a falling clock edge; resolves the lanes.
module hpsp_host_model
  import hpsp_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Strobes and address
  output logic                   cs_n,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic                   type_sel,
  output logic                   mode_sel,
  // Lanes, upper group in the top byte
  output logic      [WORD_W-1:0] lanes_in,
  input  wire logic [WORD_W-1:0] lanes_out,
  input  wire logic [1:0]        lanes_oe,
  input  wire logic              xfr_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [WORD_W-1:0] drive_data = WORD_RESET;  // Host write data
  logic              drive_on   = 1'b0;        // Host owns the lanes
  logic [WORD_W-1:0] last_bus   = WORD_RESET;  // Lane level one cycle ago
  // Idle pins at time zero
  initial {cs_n, rd_n, wr_n, type_sel, mode_sel} = 5'b11100;
  // Undriven lanes flip each cycle so a stale value never looks valid
  assign lanes_in = drive_on ? drive_data :
                    {lanes_oe[1] ? lanes_out[15:8] : ~last_bus[15:8],
                     lanes_oe[0] ? lanes_out[7:0]  : ~last_bus[7:0]};
  always @(posedge clk_sys) last_bus <= lanes_in;
  // Fast mode accesses wait for ready, bounded so a hang shows up
  task automatic wait_ready(input logic mode);
    int n;
    n = 0;
    while (mode === MODE_FAST && xfr_ready !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
  endtask : wait_ready
  // One write: strobe low a cycle, commit on its rise, then a gap
  task automatic host_write(input logic mode, input logic sel, input logic [WORD_W-1:0] data);
    wait_ready(mode);
    {cs_n, wr_n, mode_sel, type_sel, drive_on, drive_data} = {2'b00, mode, sel, 1'b1, data};
    @(negedge clk_sys);
    {cs_n, wr_n, drive_on} = 3'b110;
    @(negedge clk_sys);
  endtask : host_write
  // One read: lanes sampled a cycle after the strobe drops
  task automatic host_read(input logic mode, input logic sel,
                           output logic [WORD_W-1:0] data, output logic [1:0] oe);
    wait_ready(mode);
    {cs_n, rd_n, mode_sel, type_sel} = {2'b00, mode, sel};
    @(negedge clk_sys);
    {data, oe} = {lanes_in, lanes_oe};
    {cs_n, rd_n} = 2'b11;
    @(negedge clk_sys);
  endtask : host_read
endmodule : hpsp_host_model

/* File: bench/test_host_parallel_slave_port.sv */
// Self-checking bench for the host parallel slave port.
// Assumes the host model drives pins at falling edges; core side is driven here.
`define CHK(got, exp, msg) begin n_checks++; if ((got) !== (exp)) begin err_count++; \
  $display("Error at %0t ns: %s", $time, msg); end end
module test_host_parallel_slave_port
  import hpsp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk_sys     = 1'b0;       // 25 MHz system clock
  logic              reset_n     = 1'b0;       // Held for 8 cycles
  logic              rx_ready    = 1'b0;       // Core stalls unless popping
  logic              tx_valid    = 1'b0;       // Core offer
  logic [WORD_W-1:0] tx_data     = WORD_RESET; // Outbound word
  logic [LANE_W-1:0] status_byte = 8'h00;      // Core status
  wire  logic        cs_n, rd_n, wr_n, transfer_type_select, transfer_mode_select;
  wire  logic [WORD_W-1:0] lanes_in, lanes_out;
  wire  logic [1:0]  lanes_oe;
  logic              irq, transfer_ready, rx_valid, tx_ready;
  hpsp_word_t        rx_word;
  logic [WORD_W-1:0] rd;
  logic [1:0]        oe;
  int                err_count = 0, n_checks = 0, cycles = 0;
  hpsp_port u_dut (.clk_sys, .reset_n, .cs_n, .rd_n, .wr_n, .transfer_type_select,
    .transfer_mode_select, .lower_data_lanes_in(lanes_in[7:0]),
    .upper_data_lanes_in(lanes_in[15:8]), .lower_data_lanes_out(lanes_out[7:0]),
    .upper_data_lanes_out(lanes_out[15:8]), .lower_data_lanes_oe(lanes_oe[0]),
    .upper_data_lanes_oe(lanes_oe[1]), .irq, .transfer_ready, .rx_valid, .rx_ready,
    .rx_word, .tx_valid, .tx_ready, .tx_data, .status_byte);
  hpsp_host_model u_host (.clk_sys, .cs_n, .rd_n, .wr_n, .type_sel(transfer_type_select),
    .mode_sel(transfer_mode_select), .lanes_in, .lanes_out, .lanes_oe,
    .xfr_ready(transfer_ready));
  initial forever #20 clk_sys = ~clk_sys;
  // Hang guard: the whole run needs fewer than 100 cycles
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end
  // -------------------------------------------------------------
  // Core side helpers
  // -------------------------------------------------------------
  task automatic offer(input logic [WORD_W-1:0] data);
    int n;
    n = 0;
    {tx_valid, tx_data} = {1'b1, data};
    while (tx_ready !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(tx_ready, 1'b1, "core offer refused")
    @(negedge clk_sys);
    tx_valid = 1'b0;
    // Holding register now full, so the core is held off
    `CHK(tx_ready, 1'b0, "holding not full")
  endtask : offer
  // Pop the buffer head; the core stalls for a full cycle after, so
  // back-to-back pops never flip ready twice in one time step
  task automatic pop(input hpsp_word_t exp);
    int n;
    n = 0;
    while (rx_valid !== 1'b1 && n < 50) begin
      @(negedge clk_sys);
      n++;
    end
    `CHK(rx_valid, 1'b1, "core word missing")
    `CHK(rx_word, exp, "core word")
    rx_ready = 1'b1;
    @(negedge clk_sys);
    rx_ready = 1'b0;
    @(negedge clk_sys);
  endtask : pop
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_comm_write;  // Upper lanes carry junk that must be dropped
    u_host.host_write(MODE_COMM, SEL_DATA, 16'hA55A);
    u_host.host_write(MODE_COMM, SEL_CTRL, 16'hFF3C);
    pop('{MODE_COMM, SEL_DATA, 16'h005A});
    pop('{MODE_COMM, SEL_CTRL, 16'h003C});
  endtask : t_comm_write
  task automatic t_fast_full;   // Third word waits in pending, host held off
    u_host.host_write(MODE_FAST, SEL_CTRL, 16'h1234);
    u_host.host_write(MODE_FAST, SEL_DATA, 16'h5678);
    u_host.host_write(MODE_FAST, SEL_CTRL, 16'h9ABC);
    repeat (4) @(negedge clk_sys);
    `CHK(transfer_ready, 1'b0, "ready while full")
    pop('{MODE_FAST, SEL_DATA, 16'h1234});
    pop('{MODE_FAST, SEL_DATA, 16'h5678});
    pop('{MODE_FAST, SEL_DATA, 16'h9ABC});
    repeat (4) @(negedge clk_sys);
    `CHK(transfer_ready, 1'b1, "ready after drain")
  endtask : t_fast_full
  task automatic t_status_read;
    status_byte = 8'hC3;
    u_host.host_read(MODE_COMM, SEL_CTRL, rd, oe);
    `CHK(rd[7:0], 8'hC3, "status byte")
    `CHK(oe, 2'b01, "status lane drive")
    `CHK(lanes_oe, 2'b00, "lanes released")
  endtask : t_status_read
  task automatic t_comm_read;
    offer(16'hBEEF);
    repeat (4) @(negedge clk_sys);
    `CHK(irq, 1'b1, "request with word held")
    // Status read drops the request but leaves the word held
    u_host.host_read(MODE_COMM, SEL_CTRL, rd, oe);
    `CHK(rd[7:0], 8'hC3, "status with word held")
    `CHK(irq, 1'b1, "request back after status read")
    u_host.host_read(MODE_COMM, SEL_DATA, rd, oe);
    `CHK(rd[7:0], 8'hEF, "mode 0 data")
    `CHK(oe, 2'b01, "upper idle in mode 0")
    `CHK(irq, 1'b0, "request after read")
  endtask : t_comm_read
  task automatic t_fast_read;   // Type pin flips between reads and must not matter
    offer(16'h0F1E);
    u_host.host_read(MODE_FAST, SEL_CTRL, rd, oe);
    `CHK(rd, 16'h0F1E, "fast word")
    `CHK(oe, 2'b11, "both groups driven")
    `CHK(transfer_ready, 1'b0, "ready with no word")
    offer(16'h7788);
    u_host.host_read(MODE_FAST, SEL_DATA, rd, oe);
    `CHK(rd, 16'h7788, "second fast word")
  endtask : t_fast_read
  task automatic conclude;
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    reset_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    t_comm_write();
    t_fast_full();
    t_status_read();
    t_comm_read();
    t_fast_read();
    conclude();
  end
endmodule : test_host_parallel_slave_port
bind hpsp_port hpsp_port_asserts u_asserts (.clk_sys, .reset_n, .cs_n, .rd_n, .wr_n,
  .transfer_type_select, .transfer_mode_select, .lower_data_lanes_out, .lower_data_lanes_oe,
  .upper_data_lanes_oe, .irq, .transfer_ready, .rx_valid, .rx_word, .tx_valid, .tx_ready,
  .status_byte);
